// >>> dv/dual_port_adapter_sva.sv
// checker for the dual port adapter: reset pin, bus drive and output causality
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ps
module dual_port_adapter_sva (
  // clock and reset
  input wire sys_clk,
  input wire reset,
  input wire reset_n_pin,
  // processor bus
  input wire bus_strobe,
  input wire read_not_write,
  input wire chip_select_0,
  input wire chip_select_1,
  input wire chip_select_2_n,
  input wire data_oe_n,
  // peripheral inputs
  input wire side_a_strobe_input,
  input wire side_a_control_line_in,
  input wire side_b_strobe_input,
  input wire side_b_control_line_in,
  // peripheral outputs
  input wire [7:0] side_a_lines_out,
  input wire [7:0] side_a_lines_oe_n,
  input wire [7:0] side_b_lines_out,
  input wire [7:0] side_b_lines_oe_n,
  input wire side_a_control_line_out,
  input wire side_a_control_line_oe_n,
  input wire side_b_control_line_out,
  input wire side_b_control_line_oe_n,
  input wire side_a_irq_out,
  input wire side_a_irq_out_oe_n,
  input wire side_b_irq_out,
  input wire side_b_irq_out_oe_n
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);

  // cycles since the bus strobe, reset pin or a peripheral strobe or control input moved; outputs are only allowed to move shortly after one
  wire [5:0] ins = {bus_strobe, reset_n_pin, side_a_strobe_input, side_a_control_line_in,
    side_b_strobe_input, side_b_control_line_in};
  reg [5:0] ins_r;
  reg [3:0] quiet_r;
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ins_r <= 6'h00;
      quiet_r <= 4'h0;
    end else begin
      ins_r <= ins;
      if (ins != ins_r)
        quiet_r <= 4'h0;
      else if (quiet_r != 4'hF)
        quiet_r <= quiet_r + 4'h1;
    end
  end

  property p_reset_pin_clears;
    !reset_n_pin [*6] |-> side_a_lines_oe_n == 8'hFF && side_b_lines_oe_n == 8'hFF && side_a_control_line_oe_n
      && side_b_control_line_oe_n && side_a_irq_out_oe_n && side_b_irq_out_oe_n;
  endproperty
  a_reset_pin_clears: assert property (p_reset_pin_clears) else $error("reset pin left a port set up");
  property p_data_drive;
    !data_oe_n |-> $past(bus_strobe, 3) && $past(read_not_write, 3) && $past(chip_select_0, 3)
      && $past(chip_select_1, 3) && !$past(chip_select_2_n, 3) && $past(reset_n_pin, 3);
  endproperty
  a_data_drive: assert property (p_data_drive) else $error("data bus driven outside a read");
  property p_irq_open_drain;
    side_a_irq_out == 1'h0 && side_b_irq_out == 1'h0;
  endproperty
  a_irq_open_drain: assert property (p_irq_open_drain) else $error("interrupt pin drives high");
  property p_irq_a_cause;
    $fell(side_a_irq_out_oe_n) |-> quiet_r < 4'hC;
  endproperty
  a_irq_a_cause: assert property (p_irq_a_cause) else $error("side a interrupt without cause");
  property p_irq_b_cause;
    $fell(side_b_irq_out_oe_n) |-> quiet_r < 4'hC;
  endproperty
  a_irq_b_cause: assert property (p_irq_b_cause) else $error("side b interrupt without cause");
  property p_ctl_a_cause;
    $changed(side_a_control_line_out) |-> quiet_r < 4'hC;
  endproperty
  a_ctl_a_cause: assert property (p_ctl_a_cause) else $error("side a control line moved alone");
  property p_ctl_b_cause;
    $changed(side_b_control_line_out) |-> quiet_r < 4'hC;
  endproperty
  a_ctl_b_cause: assert property (p_ctl_b_cause) else $error("side b control line moved alone");
  property p_lines_cause;
    $changed({side_a_lines_out, side_a_lines_oe_n, side_b_lines_out, side_b_lines_oe_n}) |-> quiet_r < 4'hC;
  endproperty
  a_lines_cause: assert property (p_lines_cause) else $error("port lines moved without an access");

  // main scenarios reached
  c_irq_a: cover property ($fell(side_a_irq_out_oe_n));
  c_read: cover property ($fell(data_oe_n));
  c_ctl_b_low: cover property ($fell(side_b_control_line_out));
endmodule

bind dual_port_adapter dual_port_adapter_sva dual_port_adapter_sva_i (.sys_clk, .reset, .reset_n_pin,
  .bus_strobe, .read_not_write, .chip_select_0, .chip_select_1, .chip_select_2_n, .data_oe_n,
  .side_a_strobe_input, .side_a_control_line_in, .side_b_strobe_input, .side_b_control_line_in,
  .side_a_lines_out, .side_a_lines_oe_n, .side_b_lines_out, .side_b_lines_oe_n, .side_a_control_line_out,
  .side_a_control_line_oe_n, .side_b_control_line_out, .side_b_control_line_oe_n, .side_a_irq_out,
  .side_a_irq_out_oe_n, .side_b_irq_out, .side_b_irq_out_oe_n);

// >>> dv/periph_model.sv
// peripheral side of both ports: resolves every shared wire from both parties
// assumes the bench sets what the peripheral wants to drive
`timescale 1ns/1ps
module periph_model (
  // adapter drive
  input wire [7:0] a_out,
  input wire [7:0] a_oe_n,
  input wire [7:0] b_out,
  input wire [7:0] b_oe_n,
  input wire a_ctl_out,
  input wire a_ctl_oe_n,
  input wire b_ctl_out,
  input wire b_ctl_oe_n,
  // peripheral drive
  input wire [7:0] a_drv,
  input wire [7:0] b_drv,
  input wire a_ctl_drv,
  input wire b_ctl_drv,
  // resolved wires
  output wire [7:0] a_pins,
  output wire [7:0] b_pins,
  output wire a_ctl_pin,
  output wire b_ctl_pin
);
  // no wire fights; a low b_drv on a driven side B line is a load dragging it below threshold
  assign a_pins = (a_out & ~a_oe_n) | (a_drv & a_oe_n);
  assign b_pins = (b_out & b_drv & ~b_oe_n) | (b_drv & b_oe_n);
  // control lines rest high while inputs; each level is held many cycles
  assign a_ctl_pin = a_ctl_oe_n ? a_ctl_drv : a_ctl_out;
  assign b_ctl_pin = b_ctl_oe_n ? b_ctl_drv : b_ctl_out;
endmodule

// >>> dv/testbench.sv
// self-checking bench for the dual port adapter with the peripheral model
// assumes the checker is bound in and the bus strobe is slow against sys_clk
`timescale 1ns/1ps
module testbench;
  logic sys_clk = 1'h0, reset = 1'h1, reset_n_pin = 1'h1, bus_strobe = 1'h0, read_not_write = 1'h0;
  logic chip_select_0 = 1'h0, chip_select_1 = 1'h0, chip_select_2_n = 1'h1;
  logic register_select_low = 1'h0, register_select_high = 1'h0, oe_seen;
  logic side_a_strobe_input = 1'h1, side_b_strobe_input = 1'h1, a_ctl_drv = 1'h1, b_ctl_drv = 1'h1;
  logic [7:0] data_in = 8'h00, a_drv = 8'h03, b_drv = 8'h00, rdata;
  wire [7:0] data_out, side_a_lines_in, side_a_lines_out, side_a_lines_oe_n;
  wire [7:0] side_b_lines_in, side_b_lines_out, side_b_lines_oe_n;
  wire data_oe_n, side_a_control_line_in, side_a_control_line_out, side_a_control_line_oe_n;
  wire side_b_control_line_in, side_b_control_line_out, side_b_control_line_oe_n;
  wire side_a_irq_out, side_a_irq_out_oe_n, side_b_irq_out, side_b_irq_out_oe_n;
  int i, n_mismatch = 0, checked = 0;
  // rows: register select, byte written, byte read back
  logic [17:0] rows [0:7] = '{{2'h1, 8'hFF, 8'h3F}, {2'h1, 8'h00, 8'h00}, {2'h0, 8'hF0, 8'hF0},
    {2'h2, 8'hFF, 8'hFF}, {2'h3, 8'hC4, 8'h04}, {2'h1, 8'h04, 8'h04}, {2'h2, 8'h5A, 8'h5A},
    {2'h0, 8'hA0, 8'hA3}};

  dual_port_adapter dual_port_adapter_i (.sys_clk, .reset, .reset_n_pin, .bus_strobe, .read_not_write,
    .chip_select_0, .chip_select_1, .chip_select_2_n, .register_select_low, .register_select_high, .data_in,
    .data_out, .data_oe_n, .side_a_lines_in, .side_a_lines_out, .side_a_lines_oe_n, .side_a_strobe_input,
    .side_a_control_line_in, .side_a_control_line_out, .side_a_control_line_oe_n, .side_a_irq_out,
    .side_a_irq_out_oe_n, .side_b_lines_in, .side_b_lines_out, .side_b_lines_oe_n, .side_b_strobe_input,
    .side_b_control_line_in, .side_b_control_line_out, .side_b_control_line_oe_n, .side_b_irq_out,
    .side_b_irq_out_oe_n);
  periph_model periph_model_i (.a_out(side_a_lines_out), .a_oe_n(side_a_lines_oe_n), .b_out(side_b_lines_out),
    .b_oe_n(side_b_lines_oe_n), .a_ctl_out(side_a_control_line_out), .a_ctl_oe_n(side_a_control_line_oe_n),
    .b_ctl_out(side_b_control_line_out), .b_ctl_oe_n(side_b_control_line_oe_n), .a_drv, .b_drv, .a_ctl_drv,
    .b_ctl_drv, .a_pins(side_a_lines_in), .b_pins(side_b_lines_in), .a_ctl_pin(side_a_control_line_in),
    .b_ctl_pin(side_b_control_line_in));

  initial begin
    forever #50 sys_clk = ~sys_clk;
  end

  task summarize;
    begin
      if (n_mismatch == 0 && checked > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    begin
      checked++;
      if (seen !== exp) begin
        n_mismatch++;
        $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  // one strobe pulse, selects held from its start until the next access
  task bus(input logic [2:0] cs, input logic rw, input logic [1:0] rs, input logic [7:0] wd);
    begin
      @(posedge sys_clk);
      {chip_select_0, chip_select_1, chip_select_2_n} <= cs;
      read_not_write <= rw;
      {register_select_high, register_select_low} <= rs;
      data_in <= wd;
      bus_strobe <= 1'h1;
      repeat (5) @(posedge sys_clk);
      rdata = data_out;
      oe_seen = data_oe_n;
      bus_strobe <= 1'h0;
      repeat (6) @(posedge sys_clk);
    end
  endtask

  task wr(input logic [1:0] rs, input logic [7:0] wd);
    bus(3'h6, 1'h0, rs, wd);
  endtask

  task rdc(input logic [1:0] rs, input logic [7:0] exp);
    begin
      bus(3'h6, 1'h1, rs, 8'h00);
      chk(rdata, exp);
      chk({7'h00, oe_seen}, 8'h00);
    end
  endtask

  // a strobe pulse while deselected re-arms the flags
  task desel;
    bus(3'h1, 1'h1, 2'h0, 8'h00);
  endtask

  task pin(input int k, input logic v);
    begin
      @(posedge sys_clk);
      case (k)
        0: side_a_strobe_input <= v;
        1: side_b_strobe_input <= v;
        2: a_ctl_drv <= v;
        default: b_ctl_drv <= v;
      endcase
      repeat (8) @(posedge sys_clk); // each level held 8 cycles, past the 5-cycle strobe pulse but short of a whole bus access
    end
  endtask

  function automatic logic sig(input int k);
    case (k)
      0: sig = side_a_irq_out_oe_n;
      1: sig = side_b_irq_out_oe_n;
      2: sig = side_a_control_line_out;
      default: sig = side_b_control_line_out;
    endcase
  endfunction

  // bounded wait; running out counts a mismatch and ends the run
  task wt(input int k, input logic v);
    int n;
    begin
      n = 0;
      while (sig(k) !== v && n < 40) begin
        @(posedge sys_clk);
        n++;
      end
      chk({7'h00, sig(k)}, {7'h00, v});
      if (n >= 40)
        summarize();
    end
  endtask

  initial begin
    repeat (4) @(posedge sys_clk);
    reset <= 1'h0;
    repeat (5) @(posedge sys_clk);
    for (i = 0; i < 8; i++) begin
      wr(rows[i][17:16], rows[i][15:8]);
      rdc(rows[i][17:16], rows[i][7:0]);
    end
    chk(side_a_lines_oe_n, 8'h0F);
    chk(side_a_lines_out, 8'hA0);
    chk(side_b_lines_oe_n, 8'h00);
    chk(side_b_lines_out, 8'h5A);
    // strobe flag while disabled, late enable, read clear, blocked until re-armed
    desel();
    pin(0, 1'h0);
    chk(side_a_irq_out_oe_n, 1'h1);
    rdc(2'h1, 8'h84);
    wr(2'h1, 8'h05);
    wt(0, 1'h0);
    rdc(2'h0, 8'hA3);
    wt(0, 1'h1);
    pin(0, 1'h1);
    pin(0, 1'h0);
    chk(side_a_irq_out_oe_n, 1'h1);
    wr(2'h1, 8'h07);
    desel();
    pin(0, 1'h1);
    wt(0, 1'h0);
    rdc(2'h0, 8'hA3);
    wt(0, 1'h1);
    // control line b as a rising-edge interrupt input
    wr(2'h3, 8'h1C);
    desel();
    pin(3, 1'h0);
    chk(side_b_irq_out_oe_n, 1'h1);
    pin(3, 1'h1);
    wt(1, 1'h0);
    rdc(2'h3, 8'h5C);
    rdc(2'h2, 8'h5A);
    wt(1, 1'h1);
    // side b handshake: high on strobe flag, low after a data write
    wr(2'h3, 8'h24);
    desel();
    pin(1, 1'h0);
    wt(3, 1'h1);
    chk(side_b_control_line_oe_n, 1'h0);
    pin(1, 1'h1);
    wr(2'h2, 8'h3C);
    desel();
    chk(side_b_control_line_out, 1'h0);
    // side b pulse mode
    wr(2'h3, 8'h2C);
    desel();
    desel();
    chk(side_b_control_line_out, 1'h1);
    wr(2'h2, 8'hC3);
    desel();
    chk(side_b_control_line_out, 1'h0);
    desel();
    chk(side_b_control_line_out, 1'h1);
    // side b static levels
    wr(2'h3, 8'h34);
    wt(3, 1'h0);
    wr(2'h3, 8'h3C);
    wt(3, 1'h1);
    // side a handshake, then pulse mode
    wr(2'h1, 8'h24);
    rdc(2'h0, 8'hA3);
    wt(2, 1'h0);
    chk(side_a_control_line_oe_n, 1'h0);
    desel();
    pin(0, 1'h0);
    wt(2, 1'h1);
    pin(0, 1'h1);
    wr(2'h1, 8'h2C);
    rdc(2'h0, 8'hA3);
    wt(2, 1'h0);
    desel();
    wt(2, 1'h1);
    // reset pin in mid-run clears everything
    @(posedge sys_clk);
    reset_n_pin <= 1'h0;
    repeat (8) @(posedge sys_clk);
    reset_n_pin <= 1'h1;
    repeat (4) @(posedge sys_clk);
    chk(side_a_lines_oe_n, 8'hFF);
    chk(side_b_lines_oe_n, 8'hFF);
    rdc(2'h1, 8'h00);
    rdc(2'h3, 8'h00);
    rdc(2'h0, 8'h00);
    summarize();
  end
endmodule

// >>> src/dual_port_adapter.v
// dual 8-bit peripheral port adapter: register file, direction control,
// strobe and control line interrupt flags, handshake and pulse outputs
// assumes bus strobe, selects and data are pins, synchronised here before use
//
// Behaviour
// RL1 - select 00 data or direction A by access bit, 01 control A, 10/11 likewise B
// RL2 - reset pin low clears every register: all lines inputs, interrupts off
// RL3 - direction bit 1 drives line from output register, 0 makes it input
// RL4 - side B inputs float; side B data read returns output register for outputs
// RL5 - control bits 0 to 5 writable and readable, bits 6 and 7 read only
// RL6 - flags set only by input edges, both cleared by reading side data
// RL7 - bit 0 enables strobe flag onto active-low interrupt output
// RL8 - bit 1 picks strobe edge: 0 falling, 1 rising
// RL9 - a pending flag interrupts once its enable is later written to 1
// RL10 - bit 5 low makes control line an interrupt input setting flag 6
// RL11 - in input mode bit 4 picks edge, bit 3 enables flag 6
// RL12 - bit 5 high makes control line an output chosen by bits 4 and 3
// RL13 - B handshake: low at strobe rise after data write, high on strobe flag
// RL14 - B pulse: low after data write, high after a deselected strobe cycle
// RL15 - B bits 5 and 4 high drive control line to bit 3
// RL16 - peripheral holds interrupt pulses longer than one strobe cycle
// RL17 - peripheral keeps interrupt inputs idle high, notably during reset
// RL18 - A handshake: low at strobe fall after data read, high on strobe flag
// RL19 - A pulse: low after data read, high at first deselected strobe fall
// RL20 - a cleared flag stays blocked until a deselected strobe cycle
// RL21 - side A data read returns live pin levels on all lines
// RL22 - writes and read-clears happen at the strobe trailing edge when selected
`timescale 1ns/1ps
`include "dual_port_adapter_regs.vh"
module dual_port_adapter (
  // clock and reset
  input wire sys_clk,
  input wire reset,
  input wire reset_n_pin,
  // processor bus
  input wire bus_strobe,
  input wire read_not_write,
  input wire chip_select_0,
  input wire chip_select_1,
  input wire chip_select_2_n,
  input wire register_select_low,
  input wire register_select_high,
  input wire [7:0] data_in,
  output reg [7:0] data_out,
  output reg data_oe_n,
  // side A peripheral
  input wire [7:0] side_a_lines_in,
  output wire [7:0] side_a_lines_out,
  output wire [7:0] side_a_lines_oe_n,
  input wire side_a_strobe_input,
  input wire side_a_control_line_in,
  output wire side_a_control_line_out,
  output wire side_a_control_line_oe_n,
  output wire side_a_irq_out,
  output reg side_a_irq_out_oe_n,
  // side B peripheral
  input wire [7:0] side_b_lines_in,
  output wire [7:0] side_b_lines_out,
  output wire [7:0] side_b_lines_oe_n,
  input wire side_b_strobe_input,
  input wire side_b_control_line_in,
  output wire side_b_control_line_out,
  output wire side_b_control_line_oe_n,
  output wire side_b_irq_out,
  output reg side_b_irq_out_oe_n
);

  // synchronised pins
  wire [`PIN_SYNC_WIDTH-1:0] pins_s;
  wire strobe_s;
  wire rw_s;
  wire sel_s;
  wire [1:0] rsel_s;
  wire [7:0] wdata_s;
  wire [7:0] a_lines_s;
  wire [7:0] b_lines_s;
  wire a_strobe_s;
  wire a_line_s;
  wire b_strobe_s;
  wire b_line_s;
  wire res_n_s;

  // registers
  reg [7:0] out_a_r;
  reg [7:0] dir_a_r;
  reg [7:0] ctrl_a_r;
  reg [7:0] out_b_r;
  reg [7:0] dir_b_r;
  reg [7:0] ctrl_b_r;
  reg [7:0] ctrl_a_nxt;
  reg [7:0] ctrl_b_nxt;
  reg arm_a_r;
  reg arm_b_r;
  reg ctl_a_r;
  reg ctl_b_r;
  reg ctl_a_nxt;
  reg ctl_b_nxt;
  reg pend_b_r;
  reg desel_b_r;
  reg strobe_prev_r;
  reg [7:0] rdata_nxt;

  // every pin passes two flops, including the data bus and the reset pin
  pin_sync #(
    .WIDTH(`PIN_SYNC_WIDTH)
  ) u_pin_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .pin_in({reset_n_pin, side_b_control_line_in, side_b_strobe_input,
             side_a_control_line_in, side_a_strobe_input, side_b_lines_in, side_a_lines_in,
             data_in, register_select_high, register_select_low,
             chip_select_2_n, chip_select_1, chip_select_0, read_not_write, bus_strobe}),
    .pin_sync_out(pins_s)
  );

  assign strobe_s = pins_s[0];
  assign rw_s = pins_s[1];
  assign sel_s = pins_s[2] & pins_s[3] & ~pins_s[4];
  assign rsel_s = pins_s[6:5];
  assign wdata_s = pins_s[14:7];
  assign a_lines_s = pins_s[22:15];
  assign b_lines_s = pins_s[30:23];
  assign a_strobe_s = pins_s[31];
  assign a_line_s = pins_s[32];
  assign b_strobe_s = pins_s[33];
  assign b_line_s = pins_s[34];
  assign res_n_s = pins_s[35];

  // bus strobe edges seen on sys_clk
  wire strobe_rise = strobe_s & ~strobe_prev_r;
  wire strobe_fall = ~strobe_s & strobe_prev_r;

  // trailing-edge access strobes while selected, and the trailing edge while deselected
  wire wr_stb = strobe_fall & sel_s & ~rw_s; // [RL22]
  wire rd_stb = strobe_fall & sel_s & rw_s; // [RL22]
  wire desel_fall = strobe_fall & ~sel_s;

  // register decode with the direction-access bits
  wire hit_a_data = (rsel_s == `RSEL_A_DATA) & ctrl_a_r[`CTL_DIR_ACCESS]; // [RL1]
  wire hit_a_dir = (rsel_s == `RSEL_A_DATA) & ~ctrl_a_r[`CTL_DIR_ACCESS]; // [RL1]
  wire hit_a_ctrl = (rsel_s == `RSEL_A_CTRL); // [RL1]
  wire hit_b_data = (rsel_s == `RSEL_B_DATA) & ctrl_b_r[`CTL_DIR_ACCESS]; // [RL1]
  wire hit_b_dir = (rsel_s == `RSEL_B_DATA) & ~ctrl_b_r[`CTL_DIR_ACCESS]; // [RL1]
  wire hit_b_ctrl = (rsel_s == `RSEL_B_CTRL); // [RL1]

  wire rd_a_data = rd_stb & hit_a_data;
  wire rd_b_data = rd_stb & hit_b_data;
  wire wr_b_data = wr_stb & hit_b_data;

  // interrupt input edge detectors
  wire a_strobe_edge;
  wire a_line_edge;
  wire b_strobe_edge;
  wire b_line_edge;

  edge_detect u_edge_a_strobe (
    .sys_clk(sys_clk),
    .reset(reset),
    .sig(a_strobe_s),
    .rise_sel(ctrl_a_r[`CTL_STROBE_EDGE]), // [RL8]
    .edge_pulse(a_strobe_edge)
  );

  edge_detect u_edge_a_line (
    .sys_clk(sys_clk),
    .reset(reset),
    .sig(a_line_s),
    .rise_sel(ctrl_a_r[`CTL_LINE_CFG_MID]), // [RL11]
    .edge_pulse(a_line_edge)
  );

  edge_detect u_edge_b_strobe (
    .sys_clk(sys_clk),
    .reset(reset),
    .sig(b_strobe_s),
    .rise_sel(ctrl_b_r[`CTL_STROBE_EDGE]), // [RL8]
    .edge_pulse(b_strobe_edge)
  );

  edge_detect u_edge_b_line (
    .sys_clk(sys_clk),
    .reset(reset),
    .sig(b_line_s),
    .rise_sel(ctrl_b_r[`CTL_LINE_CFG_MID]), // [RL11]
    .edge_pulse(b_line_edge)
  );

  // flag sets are gated by the arm bits, control line only in input mode
  wire a_strobe_set = a_strobe_edge & arm_a_r; // [RL6] [RL20]
  wire a_line_set = a_line_edge & arm_a_r & ~ctrl_a_r[`CTL_LINE_OUT_SEL]; // [RL10]
  wire b_strobe_set = b_strobe_edge & arm_b_r; // [RL6] [RL20]
  wire b_line_set = b_line_edge & arm_b_r & ~ctrl_b_r[`CTL_LINE_OUT_SEL]; // [RL10]

  // next control words: writes touch bits 0-5, reads clear flags, sets win last
  always @* begin
    ctrl_a_nxt = ctrl_a_r;
    ctrl_b_nxt = ctrl_b_r;
    if (wr_stb & hit_a_ctrl) begin
      ctrl_a_nxt = (wdata_s & `CTL_WRITE_MASK) | (ctrl_a_r & ~`CTL_WRITE_MASK); // [RL5]
    end
    if (wr_stb & hit_b_ctrl) begin
      ctrl_b_nxt = (wdata_s & `CTL_WRITE_MASK) | (ctrl_b_r & ~`CTL_WRITE_MASK); // [RL5]
    end
    if (rd_a_data) begin
      ctrl_a_nxt[`CTL_STROBE_FLAG] = 1'b0; // [RL6]
      ctrl_a_nxt[`CTL_LINE_FLAG] = 1'b0;
    end
    if (rd_b_data) begin
      ctrl_b_nxt[`CTL_STROBE_FLAG] = 1'b0; // [RL6]
      ctrl_b_nxt[`CTL_LINE_FLAG] = 1'b0;
    end
    // an edge in the clearing cycle is kept rather than lost
    if (a_strobe_set) begin
      ctrl_a_nxt[`CTL_STROBE_FLAG] = 1'b1;
    end
    if (a_line_set) begin
      ctrl_a_nxt[`CTL_LINE_FLAG] = 1'b1;
    end
    if (b_strobe_set) begin
      ctrl_b_nxt[`CTL_STROBE_FLAG] = 1'b1;
    end
    if (b_line_set) begin
      ctrl_b_nxt[`CTL_LINE_FLAG] = 1'b1;
    end
  end

  // side A control line output modes
  always @* begin
    ctl_a_nxt = ctl_a_r;
    if (ctrl_a_r[`CTL_LINE_OUT_SEL]) begin // [RL12]
      if (ctrl_a_r[`CTL_LINE_CFG_MID]) begin
        ctl_a_nxt = ctrl_a_r[`CTL_LINE_CFG_LOW];
      end else if (rd_a_data) begin
        ctl_a_nxt = 1'b0; // [RL18] [RL19]
      end else if (ctrl_a_r[`CTL_LINE_CFG_LOW]) begin
        if (desel_fall) begin
          ctl_a_nxt = 1'b1; // [RL19]
        end
      end else if (a_strobe_set) begin
        ctl_a_nxt = 1'b1; // [RL18]
      end
    end
  end

  // side B control line output modes, handshake low and both pulse steps keyed to the strobe leading edge
  always @* begin
    ctl_b_nxt = ctl_b_r;
    if (ctrl_b_r[`CTL_LINE_OUT_SEL]) begin // [RL12]
      case (ctrl_b_r[`CTL_LINE_CFG_MID:`CTL_LINE_CFG_LOW])
        `LINE_MODE_HANDSHAKE: begin
          if (strobe_rise & pend_b_r) begin
            ctl_b_nxt = 1'b0; // [RL13]
          end else if (b_strobe_set) begin
            ctl_b_nxt = 1'b1; // [RL13]
          end
        end
        `LINE_MODE_PULSE: begin
          if (strobe_rise & pend_b_r) begin
            ctl_b_nxt = 1'b0; // [RL14]
          end else if (strobe_rise & desel_b_r) begin
            ctl_b_nxt = 1'b1; // [RL14]
          end
        end
        default: begin
          ctl_b_nxt = ctrl_b_r[`CTL_LINE_CFG_LOW]; // [RL15]
        end
      endcase
    end
  end

  // strobe history; not cleared by the reset pin so edges stay meaningful
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      strobe_prev_r <= 1'b0;
    end else begin
      strobe_prev_r <= strobe_s;
    end
  end

  // register file, arm bits and handshake state
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      out_a_r <= `REG_RESET;
      dir_a_r <= `REG_RESET;
      ctrl_a_r <= `REG_RESET;
      out_b_r <= `REG_RESET;
      dir_b_r <= `REG_RESET;
      ctrl_b_r <= `REG_RESET;
      arm_a_r <= 1'b0;
      arm_b_r <= 1'b0;
      ctl_a_r <= 1'b0;
      ctl_b_r <= 1'b0;
      pend_b_r <= 1'b0;
      desel_b_r <= 1'b0;
    end else if (~res_n_s) begin
      // the reset pin holds everything cleared for as long as it is low
      out_a_r <= `REG_RESET; // [RL2]
      dir_a_r <= `REG_RESET;
      ctrl_a_r <= `REG_RESET;
      out_b_r <= `REG_RESET;
      dir_b_r <= `REG_RESET;
      ctrl_b_r <= `REG_RESET;
      arm_a_r <= 1'b0;
      arm_b_r <= 1'b0;
      ctl_a_r <= 1'b0;
      ctl_b_r <= 1'b0;
      pend_b_r <= 1'b0;
      desel_b_r <= 1'b0;
    end else begin
      if (wr_stb & hit_a_data) begin
        out_a_r <= wdata_s; // [RL22]
      end
      if (wr_stb & hit_a_dir) begin
        dir_a_r <= wdata_s;
      end
      if (wr_b_data) begin
        out_b_r <= wdata_s;
      end
      if (wr_stb & hit_b_dir) begin
        dir_b_r <= wdata_s;
      end
      ctrl_a_r <= ctrl_a_nxt;
      ctrl_b_r <= ctrl_b_nxt;
      // a read-clear disarms; a strobe cycle while deselected re-arms
      if (rd_a_data) begin
        arm_a_r <= 1'b0; // [RL20]
      end else if (desel_fall) begin
        arm_a_r <= 1'b1; // [RL20]
      end
      if (rd_b_data) begin
        arm_b_r <= 1'b0; // [RL20]
      end else if (desel_fall) begin
        arm_b_r <= 1'b1; // [RL20]
      end
      ctl_a_r <= ctl_a_nxt;
      ctl_b_r <= ctl_b_nxt;
      // write pending until the next leading edge acts on it
      if (wr_b_data) begin
        pend_b_r <= 1'b1;
      end else if (strobe_rise) begin
        pend_b_r <= 1'b0;
      end
      // remembers a deselected strobe pulse for the following leading edge
      if (desel_fall) begin
        desel_b_r <= 1'b1;
      end else if (strobe_rise) begin
        desel_b_r <= 1'b0;
      end
    end
  end

  // read mux: side A shows live pins, side B shows output bits for output lines
  always @* begin
    case (rsel_s)
      `RSEL_A_DATA: begin
        rdata_nxt = ctrl_a_r[`CTL_DIR_ACCESS] ? a_lines_s : dir_a_r; // [RL21]
      end
      `RSEL_A_CTRL: begin
        rdata_nxt = ctrl_a_r; // [RL5]
      end
      `RSEL_B_DATA: begin
        rdata_nxt = ctrl_b_r[`CTL_DIR_ACCESS] ? ((out_b_r & dir_b_r) | (b_lines_s & ~dir_b_r)) : dir_b_r; // [RL4]
      end
      default: begin
        rdata_nxt = ctrl_b_r;
      end
    endcase
  end

  // data bus driven only in a selected read while the strobe is high
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      data_out <= `REG_RESET;
      data_oe_n <= 1'b1;
    end else begin
      data_out <= rdata_nxt;
      data_oe_n <= ~(sel_s & rw_s & strobe_s & res_n_s);
    end
  end

  // interrupt outputs: level from flag and enable, so a late enable still fires
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      side_a_irq_out_oe_n <= 1'b1;
      side_b_irq_out_oe_n <= 1'b1;
    end else begin
      side_a_irq_out_oe_n <= ~((ctrl_a_r[`CTL_STROBE_FLAG] & ctrl_a_r[`CTL_STROBE_IRQ_EN]) | // [RL7] [RL9]
        (ctrl_a_r[`CTL_LINE_FLAG] & ctrl_a_r[`CTL_LINE_CFG_LOW] & ~ctrl_a_r[`CTL_LINE_OUT_SEL])); // [RL11]
      side_b_irq_out_oe_n <= ~((ctrl_b_r[`CTL_STROBE_FLAG] & ctrl_b_r[`CTL_STROBE_IRQ_EN]) | // [RL7] [RL9]
        (ctrl_b_r[`CTL_LINE_FLAG] & ctrl_b_r[`CTL_LINE_CFG_LOW] & ~ctrl_b_r[`CTL_LINE_OUT_SEL])); // [RL11]
    end
  end

  // open-drain interrupt lines only ever pull low
  assign side_a_irq_out = 1'b0;
  assign side_b_irq_out = 1'b0;

  // port lines follow the direction registers; inputs are released
  assign side_a_lines_out = out_a_r; // [RL3]
  assign side_a_lines_oe_n = dir_a_r ^ `BYTE_ALL_ONES; // [RL3]
  assign side_b_lines_out = out_b_r; // [RL3]
  assign side_b_lines_oe_n = dir_b_r ^ `BYTE_ALL_ONES; // [RL4]

  // control lines drive only in output mode
  assign side_a_control_line_out = ctl_a_r;
  assign side_a_control_line_oe_n = ~ctrl_a_r[`CTL_LINE_OUT_SEL]; // [RL12]
  assign side_b_control_line_out = ctl_b_r;
  assign side_b_control_line_oe_n = ~ctrl_b_r[`CTL_LINE_OUT_SEL]; // [RL12]

endmodule

// >>> src/dual_port_adapter_regs.vh
// register selects, control word fields and reset values of the dual port adapter
// assumes the includer works in plain verilog-2005 and uses these names only
`ifndef DUAL_PORT_ADAPTER_REGS_VH
`define DUAL_PORT_ADAPTER_REGS_VH

// register select codes, high select bit first
`define RSEL_A_DATA 2'h0
`define RSEL_A_CTRL 2'h1
`define RSEL_B_DATA 2'h2
`define RSEL_B_CTRL 2'h3

// control word bit positions
`define CTL_STROBE_IRQ_EN 0
`define CTL_STROBE_EDGE 1
`define CTL_DIR_ACCESS 2
`define CTL_LINE_CFG_LOW 3
`define CTL_LINE_CFG_MID 4
`define CTL_LINE_OUT_SEL 5
`define CTL_LINE_FLAG 6
`define CTL_STROBE_FLAG 7

// software may only write the low six control bits
`define CTL_WRITE_MASK 8'h3F
`define REG_RESET 8'h00
`define BYTE_ALL_ONES 8'hFF

// control line output sub-modes held in bits 4 and 3
`define LINE_MODE_HANDSHAKE 2'h0
`define LINE_MODE_PULSE 2'h1

// width of the bundle of pin inputs that is synchronised
`define PIN_SYNC_WIDTH 36

`endif

// >>> src/edge_detect.v
// edge detector with selectable active edge for one interrupt input
// assumes sig is already synchronised to sys_clk
`timescale 1ns/1ps
module edge_detect (
  // clock and reset
  input wire sys_clk,
  input wire reset,
  // sampled line and edge choice, 1 picks rising
  input wire sig,
  input wire rise_sel,
  // one-cycle pulse on the chosen edge
  output wire edge_pulse
);

  reg prev_r;

  // previous sample, idle level taken as low after reset
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= sig;
    end
  end

  assign edge_pulse = rise_sel ? (sig & ~prev_r) : (~sig & prev_r);

endmodule

// >>> src/pin_sync.v
// two-flop synchroniser for a bundle of pin inputs
// assumes the pins are asynchronous to sys_clk and each bit may be sampled alone
`timescale 1ns/1ps
module pin_sync #(
  parameter WIDTH = 1
) (
  // clock and reset
  input wire sys_clk,
  input wire reset,
  // pins in, synchronised copy out
  input wire [WIDTH-1:0] pin_in,
  output reg [WIDTH-1:0] pin_sync_out
);

  reg [WIDTH-1:0] meta_r;

  // first stage feeds only the second stage
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      meta_r <= {WIDTH{1'b0}};
      pin_sync_out <= {WIDTH{1'b0}};
    end else begin
      meta_r <= pin_in;
      pin_sync_out <= meta_r;
    end
  end

endmodule
